// ### dv/ctm_event_net.sv
/*
 * Event routing model: drives the capture event line of the timer.
 * Assumes its task is called from the bench on the bench clock.
 */
`timescale 1ns/1ps

module ctm_event_net (
  input wire ref_clk_in,
  output logic event_out
);
  initial event_out = 1'b0;

  // ------------------------------------------------------------
  // Level change, then hold for at least one clock
  // ------------------------------------------------------------
  task automatic flip(input int hold);
    @(posedge ref_clk_in);
    event_out <= ~event_out;
    repeat ((hold < 1) ? 1 : hold) @(posedge ref_clk_in);
  endtask
endmodule // ctm_event_net

// ### dv/ctm_timer_sva.sv
/*
 * Checker of the capture timer ports: event pulse, interrupt, reads.
 * Assumes bus strobes are single cycles and never both high.
 */
`timescale 1ns/1ps
`include "ctm_regs.vh"

module ctm_timer_sva (
  input wire ref_clk_in,
  input wire reset_in,
  input wire [3:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rd_data_out,
  input wire power_down_in,
  input wire capture_event_out,
  input wire irq_out
);
  // ------------------------------------------------------------
  // Shadow of interrupt enable and capture flag
  // ------------------------------------------------------------
  logic en_reg;
  logic kept_reg;
  logic reset_hold_reg;
  wire flag_now = capture_event_out | kept_reg;
  wire clr_w1c = wr_in && (addr_in == `CTM_OFS_INTERRUPT_FLAG_BITS)
                 && wr_data_in[0];
  wire clr_rd = rd_in && (addr_in == `CTM_OFS_CCV_LO);

  // Keeps checks off for one edge after reset drops
  always @(posedge ref_clk_in) begin
    reset_hold_reg <= reset_in;
    if (reset_in) begin
      en_reg <= 1'b0;
      kept_reg <= 1'b0;
    end else begin
      if (wr_in && addr_in == `CTM_OFS_INTERRUPT_ENABLE) begin
        en_reg <= wr_data_in[0];
      end
      kept_reg <= flag_now & ~(clr_w1c | clr_rd);
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in || reset_hold_reg);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_pulse_one_cycle: assert property (
    capture_event_out |=> !capture_event_out)
    else $error("capture pulse longer than one cycle");
  a_pulse_no_repeat: assert property (
    capture_event_out |-> !kept_reg)
    else $error("capture pulse while flag already set");
  a_irq_from_flag: assert property (
    irq_out == $past(en_reg && flag_now))
    else $error("irq not enable and flag of previous cycle");
  a_irq_stays_set: assert property (
    (irq_out && en_reg && flag_now) |=> irq_out)
    else $error("irq dropped while flag set");
  a_read_clears_flag: assert property (
    clr_rd ##1 !capture_event_out |=> !irq_out)
    else $error("low compare read did not clear flag");
  a_w1c_clears_flag: assert property (
    clr_w1c ##1 !capture_event_out |=> !irq_out)
    else $error("flag write of one did not clear flag");
  a_enable_readback: assert property (
    (rd_in && addr_in == `CTM_OFS_INTERRUPT_ENABLE)
    |=> rd_data_out == {7'h00, $past(en_reg)})
    else $error("interrupt enable reads back wrong");
  a_power_down_halt: assert property (
    power_down_in [*2] |=> !capture_event_out)
    else $error("capture pulse in power down");
  a_read_data_idle: assert property (
    !$past(rd_in) |-> rd_data_out == 8'h00)
    else $error("read data outside read cycle");

  c_capture: cover property (capture_event_out && en_reg);
  c_read_clear: cover property (irq_out && clr_rd);
  c_w1c_clear: cover property (irq_out && clr_w1c);
endmodule // ctm_timer_sva

bind ctm_timer ctm_timer_sva u_sva (
  .ref_clk_in(ref_clk_in),
  .reset_in(reset_in),
  .addr_in(addr_in),
  .wr_data_in(wr_data_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rd_data_out(rd_data_out),
  .power_down_in(power_down_in),
  .capture_event_out(capture_event_out),
  .irq_out(irq_out)
);

// ### dv/tb_top.sv
/*
 * Self-checking bench of the capture timer: registers, event capture,
 * interrupt, sleep halting. Assumes the checker is bound to the timer.
 */
`timescale 1ns/1ps
`include "ctm_regs.vh"

module tb_top;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} ctm_row_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic standby = 1'b0;
  logic power_down = 1'b0;
  logic [7:0] rd_data;
  logic [7:0] d;
  logic ev;
  logic cap;
  logic irq;
  logic wave;
  int err_total = 0;
  int comparisons = 0;
  ctm_row_t rows [9] = '{
    '{`CTM_OFS_CONTROL_A, 8'hFF, `CTM_MASK_CONTROL_A},
    '{`CTM_OFS_CONTROL_B, 8'hFF, `CTM_MASK_CONTROL_B},
    '{`CTM_OFS_EVENT_CONTROL, 8'hFF, `CTM_MASK_EVENT_CONTROL},
    '{`CTM_OFS_INTERRUPT_ENABLE, 8'hFF, `CTM_MASK_SINGLE_BIT},
    '{`CTM_OFS_INTERRUPT_FLAG_BITS, 8'hFF, 8'h00},
    '{`CTM_OFS_COUNTING_STATE, 8'hFF, 8'h00},
    '{`CTM_OFS_DEBUG_CONTROL, 8'hFF, `CTM_MASK_SINGLE_BIT},
    '{4'h2, 8'hFF, 8'h00},
    '{4'hE, 8'hFF, 8'h00}};

  always #50 ref_clk = ~ref_clk;

  ctm_event_net u_evt (.ref_clk_in(ref_clk), .event_out(ev));

  ctm_timer u_dut (
    .ref_clk_in(ref_clk), .reset_in(reset), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data),
    .event_in(ev), .shared_tick_in(1'b0), .shared_restart_in(1'b0),
    .standby_in(standby), .power_down_in(power_down),
    .debug_halt_in(1'b0), .capture_event_out(cap), .irq_out(irq),
    .wave_out(wave));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    v = rd_data;
  endtask

  // One event edge, counting capture pulses that follow it
  task automatic ev_edge(input int exp_cnt);
    int cnt;
    cnt = 0;
    fork
      u_evt.flip(4);
      repeat (6) begin
        @(negedge ref_clk);
        if (cap === 1'b1) cnt++;
      end
    join
    chk(cnt[7:0], exp_cnt[7:0]);
  endtask

  task automatic irq_is(input logic exp);
    repeat (2) @(negedge ref_clk);
    chk({7'h00, irq}, {7'h00, exp});
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      bus_rd(rows[i].a, d);
      chk(d, `CTM_RESET_BYTE);
      bus_wr(rows[i].a, rows[i].w);
      bus_rd(rows[i].a, d);
      chk(d, rows[i].e);
      bus_wr(rows[i].a, 8'h00);
    end
    // Capture on rising edge, flag sticky, cleared by low read
    bus_wr(`CTM_OFS_CONTROL_B, {5'h06, `CTM_MODE_CAPTURE});
    bus_wr(`CTM_OFS_EVENT_CONTROL, 8'h01);
    bus_wr(`CTM_OFS_INTERRUPT_ENABLE, 8'h01);
    bus_wr(`CTM_OFS_CONTROL_A, 8'h01);
    bus_wr(`CTM_OFS_INTERRUPT_FLAG_BITS, 8'h01);
    ev_edge(1);
    irq_is(1'b1);
    chk({7'h00, wave}, 8'h01);
    ev_edge(0);
    ev_edge(0);
    irq_is(1'b1);
    bus_rd(`CTM_OFS_CCV_LO, d);
    irq_is(1'b0);
    // Falling edge select, then input disabled
    bus_wr(`CTM_OFS_EVENT_CONTROL, 8'h11);
    ev_edge(1);
    bus_wr(`CTM_OFS_INTERRUPT_FLAG_BITS, 8'h01);
    ev_edge(0);
    bus_wr(`CTM_OFS_EVENT_CONTROL, 8'h10);
    ev_edge(0);
    // Masked source, then unmasked, then cleared
    bus_wr(`CTM_OFS_EVENT_CONTROL, 8'h01);
    bus_wr(`CTM_OFS_INTERRUPT_ENABLE, 8'h00);
    ev_edge(1);
    irq_is(1'b0);
    bus_wr(`CTM_OFS_INTERRUPT_ENABLE, 8'h01);
    irq_is(1'b1);
    bus_wr(`CTM_OFS_INTERRUPT_FLAG_BITS, 8'h01);
    irq_is(1'b0);
    // Sleep modes, edges in pairs so the level is back on wake
    bus_wr(`CTM_OFS_EVENT_CONTROL, 8'h11);
    @(posedge ref_clk);
    standby <= 1'b1;
    ev_edge(0);
    ev_edge(0);
    bus_wr(`CTM_OFS_CONTROL_A, 8'h41);
    ev_edge(1);
    bus_wr(`CTM_OFS_INTERRUPT_FLAG_BITS, 8'h01);
    ev_edge(0);
    @(posedge ref_clk);
    power_down <= 1'b1;
    ev_edge(0);
    ev_edge(0);
    @(posedge ref_clk);
    power_down <= 1'b0;
    bus_wr(`CTM_OFS_CONTROL_A, 8'h05);
    ev_edge(1);
    irq_is(1'b1);
    // Reset in mid-run with the flag set
    @(posedge ref_clk);
    reset <= 1'b1;
    standby <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    irq_is(1'b0);
    bus_rd(`CTM_OFS_INTERRUPT_ENABLE, d);
    chk(d, `CTM_RESET_BYTE);
    // Periodic top match sets flag and pulses once
    bus_wr(`CTM_OFS_CCV_LO, 8'h03);
    bus_wr(`CTM_OFS_CCV_HI, 8'h00);
    bus_wr(`CTM_OFS_CONTROL_A, 8'h01);
    ev_edge(1);
    bus_rd(`CTM_OFS_INTERRUPT_FLAG_BITS, d);
    chk(d, 8'h01);
    bus_rd(`CTM_OFS_INTERRUPT_ENABLE, d);
    chk(d, `CTM_RESET_BYTE);
    report_and_stop();
  end
endmodule // tb_top

// ### shared/ctm_regs.vh
/*
 * Register map, field positions, reset values and codes of the
 * capture timer. Assumes byte-wide registers at the listed offsets.
 */
`ifndef CTM_REGS_VH
`define CTM_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CTM_OFS_CONTROL_A 4'h0
`define CTM_OFS_CONTROL_B 4'h1
`define CTM_OFS_EVENT_CONTROL 4'h4
`define CTM_OFS_INTERRUPT_ENABLE 4'h5
`define CTM_OFS_INTERRUPT_FLAG_BITS 4'h6
`define CTM_OFS_COUNTING_STATE 4'h7
`define CTM_OFS_DEBUG_CONTROL 4'h8
`define CTM_OFS_BYTE_STAGING 4'h9
`define CTM_OFS_COUNTER_LO 4'hA
`define CTM_OFS_COUNTER_HI 4'hB
`define CTM_OFS_CCV_LO 4'hC
`define CTM_OFS_CCV_HI 4'hD

// ----------------------------------------------------------------
// Writable bit masks and reset values
// ----------------------------------------------------------------
`define CTM_MASK_CONTROL_A 8'h57
`define CTM_MASK_CONTROL_B 8'h77
`define CTM_MASK_EVENT_CONTROL 8'h51
`define CTM_MASK_SINGLE_BIT 8'h01
`define CTM_RESET_BYTE 8'h00
`define CTM_RESET_WORD 16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTM_BIT_ENABLE 0
`define CTM_BIT_CLKSRC_LO 1
`define CTM_BIT_CLKSRC_HI 2
`define CTM_BIT_SYNC_RESTART 4
`define CTM_BIT_RUN_IN_STANDBY 6
`define CTM_BIT_MODE_LO 0
`define CTM_BIT_MODE_HI 2
`define CTM_BIT_OUT_ENABLE 4
`define CTM_BIT_OUT_INIT 5
`define CTM_BIT_UNSYNCED_TRIG 6
`define CTM_BIT_CAPTURE_EV_IN_EN 0
`define CTM_BIT_EDGE_SELECT 4
`define CTM_BIT_FILTER 6
`define CTM_BIT_CAPTURE_FLAG 0
`define CTM_BIT_KEEP_COUNTING 0

// ----------------------------------------------------------------
// Clock source and timer mode codes
// ----------------------------------------------------------------
`define CTM_CLK_SRC_DIV1 2'h0
`define CTM_CLK_SRC_DIV2 2'h1
`define CTM_CLK_SHARED 2'h2
`define CTM_MODE_PERIODIC 3'h0
`define CTM_MODE_TIMEOUT 3'h1
`define CTM_MODE_CAPTURE 3'h2
`define CTM_MODE_FREQ 3'h3
`define CTM_MODE_PULSE_WIDTH 3'h4
`define CTM_MODE_FREQ_PW 3'h5
`define CTM_MODE_SINGLE_SHOT 3'h6
`define CTM_MODE_PWM8 3'h7

`endif

// ### verilog/ctm_timer.v
/*
 * Capture timer: register file, event input and output, capture
 * interrupt, sleep and debug halting, and the counting modes.
 * Assumes all inputs but event_in are synchronous to ref_clk_in;
 * event_in is also caught by edge latches for unsynced single-shot.
 */
// Summary of operation
// (RULE1) The capture event output is a one-clock pulse raised by the same condition that sets the capture flag.
// (RULE2) With the event input enable set, each event edge does the action chosen by edge select and mode, else it is ignored.
// (RULE3) The event source holds each event level for at least one clock cycle.
// (RULE4) Single-shot with unsynced trigger catches event edges shorter than one clock cycle.
// (RULE5) An interrupt condition sets the capture flag.
// (RULE6) The capture interrupt has its own software-written enable bit.
// (RULE7) The interrupt request is high only while enable and flag are both set. The code registers irq_out, so it rises and falls one clock after them.
// (RULE8) The interrupt request stays high until the flag is cleared.
// (RULE9) By default the timer freezes as soon as standby sleep is entered.
// (RULE10) With run in standby set the timer keeps running in standby sleep.
// (RULE11) In power-down sleep the timer always halts.
// (RULE12) Reading the low byte of the compare/capture value clears the capture flag.
// (RULE13) Run in standby has no effect when the shared clock source is selected.
// (RULE14) The event pulse comes in the cycle the flag becomes set and does not repeat while it stays set.
`timescale 1ns/1ps
`include "ctm_regs.vh"

module ctm_timer #(
  parameter WIDTH = 16
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire [3:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rd_data_out,
  input wire event_in,
  input wire shared_tick_in,
  input wire shared_restart_in,
  input wire standby_in,
  input wire power_down_in,
  input wire debug_halt_in,
  output reg capture_event_out,
  output reg irq_out,
  output reg wave_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] control_a_reg;
  reg [7:0] control_b_reg;
  reg [7:0] event_control_reg;
  reg interrupt_enable_reg;
  reg capture_flag_event_reg;
  reg debug_keep_counting_reg;
  reg [7:0] byte_staging_reg;
  reg [WIDTH-1:0] counter_value_reg;
  reg [WIDTH-1:0] compare_capture_value_reg;
  reg run_reg;
  reg [1:0] phase_reg;
  reg div_reg;
  reg event_prev_reg;
  reg rise_catch_reg;
  reg fall_catch_reg;
  reg [1:0] rise_sync_reg;
  reg [1:0] fall_sync_reg;
  reg catch_clear_reg;

  reg [7:0] byte_staging_next;
  reg [WIDTH-1:0] counter_value_next;
  reg [WIDTH-1:0] compare_capture_value_next;
  reg run_next;
  reg [1:0] phase_next;
  reg capture_set;
  reg wave_next;
  reg [7:0] rd_data_next;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire enable = control_a_reg[`CTM_BIT_ENABLE];
  wire [1:0] clock_source_field =
    control_a_reg[`CTM_BIT_CLKSRC_HI:`CTM_BIT_CLKSRC_LO];
  wire sync_restart = control_a_reg[`CTM_BIT_SYNC_RESTART];
  wire run_in_standby = control_a_reg[`CTM_BIT_RUN_IN_STANDBY];
  wire [2:0] timer_mode_field =
    control_b_reg[`CTM_BIT_MODE_HI:`CTM_BIT_MODE_LO];
  wire out_enable = control_b_reg[`CTM_BIT_OUT_ENABLE];
  wire out_init = control_b_reg[`CTM_BIT_OUT_INIT];
  wire unsynced_trigger_enable = control_b_reg[`CTM_BIT_UNSYNCED_TRIG];
  wire capture_event_input_enable =
    event_control_reg[`CTM_BIT_CAPTURE_EV_IN_EN];
  wire edge_select = event_control_reg[`CTM_BIT_EDGE_SELECT];

  function wr_hit;
    input [3:0] ofs;
    begin
      wr_hit = wr_in && (addr_in == ofs);
    end
  endfunction

  function rd_hit;
    input [3:0] ofs;
    begin
      rd_hit = rd_in && (addr_in == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // Halting and count tick
  // ----------------------------------------------------------------
  wire shared_clock = (clock_source_field == `CTM_CLK_SHARED);
  wire standby_halt = standby_in && !run_in_standby && // RULE9 RULE10
    !shared_clock; // RULE13
  wire halted = power_down_in || standby_halt || // RULE11
    (debug_halt_in && !debug_keep_counting_reg);
  wire active = enable && !halted;
  wire clk_tick = (clock_source_field == `CTM_CLK_SRC_DIV1) ? 1'b1 :
    (clock_source_field == `CTM_CLK_SRC_DIV2) ? div_reg :
    shared_clock ? shared_tick_in : 1'b0;
  wire tick = active && clk_tick;

  // ----------------------------------------------------------------
  // Event edges
  // ----------------------------------------------------------------
  wire ev_ok = active && capture_event_input_enable; // RULE2
  wire pos_edge = event_in && !event_prev_reg;
  wire neg_edge = !event_in && event_prev_reg;
  wire act_a = ev_ok && (edge_select ? neg_edge : pos_edge);
  wire act_b = ev_ok && (edge_select ? pos_edge : neg_edge);
  wire unsynced = unsynced_trigger_enable &&
    (timer_mode_field == `CTM_MODE_SINGLE_SHOT);
  wire caught_rise = rise_sync_reg[1];
  wire caught_fall = fall_sync_reg[1];
  wire unsynced_trigger_enable_trig = ev_ok &&
    (caught_rise || (edge_select && caught_fall));
  wire sync_trig = ev_ok &&
    (pos_edge || (edge_select && neg_edge));
  wire single_trig = unsynced ? unsynced_trigger_enable_trig : sync_trig;
  wire at_top = (counter_value_reg == compare_capture_value_reg);
  wire [WIDTH-1:0] count_up = counter_value_reg + 1'b1;

  // Edge latches clocked by the event itself, cleared once seen
  always @(posedge event_in or posedge catch_clear_reg) begin
    if (catch_clear_reg) begin
      rise_catch_reg <= 1'b0;
    end else begin
      rise_catch_reg <= 1'b1; // RULE4
    end
  end

  always @(negedge event_in or posedge catch_clear_reg) begin
    if (catch_clear_reg) begin
      fall_catch_reg <= 1'b0;
    end else begin
      fall_catch_reg <= 1'b1; // RULE4
    end
  end

  // ----------------------------------------------------------------
  // Mode engine
  // ----------------------------------------------------------------
  always @* begin
    counter_value_next = counter_value_reg;
    compare_capture_value_next = compare_capture_value_reg;
    run_next = run_reg;
    phase_next = phase_reg;
    capture_set = 1'b0;
    wave_next = out_init;
    if (tick) begin
      counter_value_next = count_up;
    end
    case (timer_mode_field)
      `CTM_MODE_PERIODIC: begin
        if (tick && at_top) begin
          counter_value_next = {WIDTH{1'b0}};
          capture_set = 1'b1;
        end
      end
      `CTM_MODE_TIMEOUT: begin
        if (!run_reg) begin
          counter_value_next = counter_value_reg;
        end else if (tick && at_top) begin
          capture_set = 1'b1;
        end
        if (act_a) begin
          counter_value_next = {WIDTH{1'b0}};
          run_next = 1'b1;
        end else if (act_b) begin
          run_next = 1'b0;
        end
      end
      `CTM_MODE_CAPTURE: begin
        if (act_a) begin
          compare_capture_value_next = counter_value_reg;
          capture_set = 1'b1;
        end
      end
      `CTM_MODE_FREQ: begin
        if (act_a) begin
          compare_capture_value_next = counter_value_reg;
          counter_value_next = {WIDTH{1'b0}};
          capture_set = 1'b1;
        end
      end
      `CTM_MODE_PULSE_WIDTH: begin
        if (act_a) begin
          counter_value_next = {WIDTH{1'b0}};
        end else if (act_b) begin
          compare_capture_value_next = counter_value_reg;
          capture_set = 1'b1;
        end
      end
      `CTM_MODE_FREQ_PW: begin
        if (!run_reg) begin
          counter_value_next = counter_value_reg;
        end
        case (phase_reg)
          2'd0: begin
            if (act_a) begin
              counter_value_next = {WIDTH{1'b0}};
              run_next = 1'b1;
              phase_next = 2'd1;
            end
          end
          2'd1: begin
            if (act_b) begin
              compare_capture_value_next = counter_value_reg;
              phase_next = 2'd2;
            end
          end
          2'd2: begin
            if (act_a) begin
              run_next = 1'b0;
              capture_set = 1'b1;
              phase_next = 2'd3;
            end
          end
          default: begin
            if (!capture_flag_event_reg) begin
              phase_next = 2'd0;
            end
          end
        endcase
      end
      `CTM_MODE_SINGLE_SHOT: begin
        if (!run_reg) begin
          counter_value_next = counter_value_reg;
          if (single_trig) begin
            counter_value_next = {WIDTH{1'b0}};
            run_next = 1'b1;
          end
        end else if (tick && at_top) begin
          run_next = 1'b0;
          capture_set = 1'b1;
        end
        wave_next = run_next || (unsynced && single_trig);
      end
      `CTM_MODE_PWM8: begin
        if (tick && counter_value_reg[7:0] ==
            compare_capture_value_reg[7:0]) begin
          counter_value_next = {WIDTH{1'b0}};
          capture_set = 1'b1;
        end
        wave_next = enable && (counter_value_next[7:0] <
          compare_capture_value_reg[15:8]);
      end
      default: begin
        capture_set = 1'b0;
      end
    endcase
    if (sync_restart && shared_restart_in && active) begin
      counter_value_next = {WIDTH{1'b0}};
    end
    if (!enable) begin
      run_next = 1'b0;
      phase_next = 2'd0;
    end
  end

  // ----------------------------------------------------------------
  // Bus read path and 16-bit staging
  // ----------------------------------------------------------------
  always @* begin
    rd_data_next = `CTM_RESET_BYTE;
    byte_staging_next = byte_staging_reg;
    if (rd_in) begin
      case (addr_in)
        `CTM_OFS_CONTROL_A: rd_data_next = control_a_reg;
        `CTM_OFS_CONTROL_B: rd_data_next = control_b_reg;
        `CTM_OFS_EVENT_CONTROL: rd_data_next = event_control_reg;
        `CTM_OFS_INTERRUPT_ENABLE: rd_data_next = {7'h00,
          interrupt_enable_reg};
        `CTM_OFS_INTERRUPT_FLAG_BITS: rd_data_next = {7'h00,
          capture_flag_event_reg};
        `CTM_OFS_COUNTING_STATE: rd_data_next = {7'h00,
          run_reg || (enable && !halted &&
          timer_mode_field != `CTM_MODE_TIMEOUT &&
          timer_mode_field != `CTM_MODE_FREQ_PW &&
          timer_mode_field != `CTM_MODE_SINGLE_SHOT)};
        `CTM_OFS_DEBUG_CONTROL: rd_data_next = {7'h00,
          debug_keep_counting_reg};
        `CTM_OFS_BYTE_STAGING: rd_data_next = byte_staging_reg;
        `CTM_OFS_COUNTER_LO: begin
          rd_data_next = counter_value_reg[7:0];
          byte_staging_next = counter_value_reg[15:8];
        end
        `CTM_OFS_CCV_LO: begin
          rd_data_next = compare_capture_value_reg[7:0];
          byte_staging_next = compare_capture_value_reg[15:8];
        end
        `CTM_OFS_COUNTER_HI: rd_data_next = byte_staging_reg;
        `CTM_OFS_CCV_HI: rd_data_next = byte_staging_reg;
        default: rd_data_next = `CTM_RESET_BYTE;
      endcase
    end
    if (wr_hit(`CTM_OFS_BYTE_STAGING) || wr_hit(`CTM_OFS_COUNTER_LO) ||
        wr_hit(`CTM_OFS_CCV_LO)) begin
      byte_staging_next = wr_data_in;
    end
  end

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  wire flag_clear = (wr_hit(`CTM_OFS_INTERRUPT_FLAG_BITS) &&
    wr_data_in[`CTM_BIT_CAPTURE_FLAG]) ||
    rd_hit(`CTM_OFS_CCV_LO); // RULE12

  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      control_a_reg <= `CTM_RESET_BYTE;
      control_b_reg <= `CTM_RESET_BYTE;
      event_control_reg <= `CTM_RESET_BYTE;
      interrupt_enable_reg <= 1'b0;
      capture_flag_event_reg <= 1'b0;
      debug_keep_counting_reg <= 1'b0;
      byte_staging_reg <= `CTM_RESET_BYTE;
      counter_value_reg <= `CTM_RESET_WORD;
      compare_capture_value_reg <= `CTM_RESET_WORD;
      run_reg <= 1'b0;
      phase_reg <= 2'd0;
      div_reg <= 1'b0;
      event_prev_reg <= 1'b0;
      rise_sync_reg <= 2'b00;
      fall_sync_reg <= 2'b00;
      catch_clear_reg <= 1'b1;
      rd_data_out <= `CTM_RESET_BYTE;
      capture_event_out <= 1'b0;
      irq_out <= 1'b0;
      wave_out <= 1'b0;
    end else begin
      if (!halted) begin
        div_reg <= !div_reg;
        event_prev_reg <= event_in;
        run_reg <= run_next;
        phase_reg <= phase_next;
        counter_value_reg <= counter_value_next;
        compare_capture_value_reg <= compare_capture_value_next;
      end
      rise_sync_reg <= {rise_sync_reg[0], rise_catch_reg};
      fall_sync_reg <= {fall_sync_reg[0], fall_catch_reg};
      catch_clear_reg <= !unsynced || caught_rise || caught_fall;
      byte_staging_reg <= byte_staging_next;
      rd_data_out <= rd_data_next;
      if (wr_hit(`CTM_OFS_CONTROL_A)) begin
        control_a_reg <= wr_data_in & `CTM_MASK_CONTROL_A;
      end
      if (wr_hit(`CTM_OFS_CONTROL_B)) begin
        control_b_reg <= wr_data_in & `CTM_MASK_CONTROL_B;
      end
      if (wr_hit(`CTM_OFS_EVENT_CONTROL)) begin
        event_control_reg <= wr_data_in & `CTM_MASK_EVENT_CONTROL;
      end
      if (wr_hit(`CTM_OFS_INTERRUPT_ENABLE)) begin
        interrupt_enable_reg <= wr_data_in[`CTM_BIT_CAPTURE_FLAG]; // RULE6
      end
      if (wr_hit(`CTM_OFS_DEBUG_CONTROL)) begin
        debug_keep_counting_reg <= wr_data_in[`CTM_BIT_KEEP_COUNTING];
      end
      if (wr_hit(`CTM_OFS_COUNTER_HI)) begin
        counter_value_reg <= {wr_data_in, byte_staging_reg};
      end
      if (wr_hit(`CTM_OFS_CCV_HI)) begin
        compare_capture_value_reg <= {wr_data_in, byte_staging_reg};
      end
      // Set beats clear in the same cycle
      if (capture_set && !halted) begin
        capture_flag_event_reg <= 1'b1; // RULE5
      end else if (flag_clear) begin
        capture_flag_event_reg <= 1'b0; // RULE8
      end
      capture_event_out <= capture_set && !halted &&
        !capture_flag_event_reg; // RULE1 RULE14
      irq_out <= interrupt_enable_reg && capture_flag_event_reg; // RULE7
      wave_out <= out_enable && (halted ? wave_out : wave_next);
    end
  end

endmodule // ctm_timer
